// [logic/rrs_unit.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Function
// RL1 - Rotate right circular: bits move toward bit 0, old bit 0 to carry and bit 7
// RL2 - Rotate through carry: shift right, old bit 0 to carry, old carry to bit 7
// RL3 - Shift left arithmetic: bits move toward bit 7, old bit 7 to carry
// RL4 - Shift left arithmetic fills result bit 0 with zero
// RL5 - Sign flag follows result bit 7 after every operation
// RL6 - Zero flag set when the result is zero, cleared otherwise
// RL7 - Parity flag set on even parity; half-carry and subtract cleared
// RL8 - Register form 8 states, pointer form 15, indexed forms 23
// RL9 - Low three operation bits select B C D E H L A as 0-5 and 7
// RL10 - Indexed form: index prefix, bit prefix, displacement, operation byte
// RL11 - Memory forms recognise 0E, 1E and 26 as the three operations
// RL12 - Register forms decode 08, 18, 20 plus register code
// RL13 - Pointer form reads, modifies and writes back byte at pointer pair
// RL14 - Indexed address is index register plus sign-extended displacement
module rrs_unit
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Operand memory
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd_en,
  output logic mem_wr_en,
  input wire logic [7:0] mem_rdata
);

  // ==========================================
  // State
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] insn;
    logic [7:0][7:0] gpr;
    logic [7:0] flags;
    logic [15:0] index_reg_first;
    logic [15:0] index_reg_second;
    logic done;
    logic ill;
    rrs_pkg::rrs_form_t form;
    rrs_pkg::rrs_kind_t kind;
    logic [2:0] rsel;
    logic [15:0] addr;
    logic [7:0] opnd;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_rd_en;
    logic mem_wr_en;
  } rrs_state_t;

  rrs_state_t st;
  rrs_state_t next_st;

  logic start_go;
  logic cnt_active;
  logic cnt_at_end;
  logic [4:0] cnt_t;
  logic [4:0] cnt_last;
  logic [4:0] rd_t;
  logic [4:0] wr_t;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] op;
  logic [31:0] wmerge;
  logic dec_ok;
  logic op_mem;
  rrs_pkg::rrs_form_t dec_form;
  rrs_pkg::rrs_kind_t dec_kind;
  logic [15:0] dec_index;

  // ==========================================
  // Register readback word
  function automatic logic [31:0] reg_word(input rrs_state_t s, input logic [7:0] a,
                                           input logic busy);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      rrs_pkg::OFF_STATUS:
      begin
        v[rrs_pkg::STAT_BUSY_BIT] = busy;
        v[rrs_pkg::STAT_DONE_BIT] = s.done;
        v[rrs_pkg::STAT_ILL_BIT] = s.ill;
      end
      rrs_pkg::OFF_INSN: v = s.insn;
      rrs_pkg::OFF_GPR_LO: v = {s.gpr[3], s.gpr[2], s.gpr[1], s.gpr[0]};
      rrs_pkg::OFF_GPR_HI: v = {s.gpr[7], 8'h00, s.gpr[5], s.gpr[4]};
      rrs_pkg::OFF_FLAGS: v = {24'h00_0000, s.flags};
      rrs_pkg::OFF_INDEX: v = {s.index_reg_second, s.index_reg_first};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================
  // Submodules
  rrs_step_count u_count
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_go),
    .last(cnt_last),
    .t_now(cnt_t),
    .active(cnt_active),
    .at_end(cnt_at_end)
  );

  rrs_shift_alu u_alu
  (
    .kind(st.kind),
    .opnd(st.opnd),
    .flags_in(st.flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  // ==========================================
  // Instruction length and memory states per form
  always_comb
  begin
    unique case (st.form)
      rrs_pkg::rrs_form_ptr:
      begin
        cnt_last = 5'(rrs_pkg::TS_PTR - 5'h01); // [RL8]
        rd_t = rrs_pkg::PTR_RD_T;
        wr_t = rrs_pkg::PTR_WR_T;
      end
      rrs_pkg::rrs_form_idx:
      begin
        cnt_last = 5'(rrs_pkg::TS_IDX - 5'h01); // [RL8]
        rd_t = rrs_pkg::IDX_RD_T;
        wr_t = rrs_pkg::IDX_WR_T;
      end
      default:
      begin
        cnt_last = 5'(rrs_pkg::TS_REG - 5'h01); // [RL8]
        rd_t = rrs_pkg::PTR_RD_T;
        wr_t = rrs_pkg::PTR_WR_T;
      end
    endcase
  end

  // ==========================================
  // Opcode decode of the stored instruction bytes
  always_comb
  begin
    b0 = st.insn[7:0];
    b1 = st.insn[15:8];
    b2 = st.insn[23:16];
    op = b1;
    dec_ok = 1'b0;
    dec_form = rrs_pkg::rrs_form_reg;
    dec_kind = rrs_pkg::rrs_rot_circ;
    dec_index = st.index_reg_first;
    if (b0 == rrs_pkg::PFX_BITOP)
    begin
      op = b1;
      dec_ok = 1'b1;
      dec_form = (op[2:0] == rrs_pkg::REG_CODE_MEM) ? rrs_pkg::rrs_form_ptr
                                                    : rrs_pkg::rrs_form_reg;
    end
    else if ((b0 == rrs_pkg::PFX_IDX_FIRST || b0 == rrs_pkg::PFX_IDX_SECOND)
             && b1 == rrs_pkg::PFX_BITOP) // [RL10]
    begin
      op = st.insn[31:24]; // [RL10]
      dec_ok = (op[2:0] == rrs_pkg::REG_CODE_MEM);
      dec_form = rrs_pkg::rrs_form_idx;
      dec_index = (b0 == rrs_pkg::PFX_IDX_FIRST) ? st.index_reg_first
                                                 : st.index_reg_second; // [RL10]
    end
    op_mem = (op[2:0] == rrs_pkg::REG_CODE_MEM);
    // Memory forms match whole bytes, register forms the upper five bits
    if (op_mem ? (op == rrs_pkg::OPM_ROT_C)
               : (op[7:3] == rrs_pkg::OPR_ROT_C_BASE[7:3])) // [RL11] [RL12]
      dec_kind = rrs_pkg::rrs_rot_circ;
    else if (op_mem ? (op == rrs_pkg::OPM_ROT_T)
                    : (op[7:3] == rrs_pkg::OPR_ROT_T_BASE[7:3])) // [RL11] [RL12]
      dec_kind = rrs_pkg::rrs_rot_carry;
    else if (op_mem ? (op == rrs_pkg::OPM_SHL)
                    : (op[7:3] == rrs_pkg::OPR_SHL_BASE[7:3])) // [RL11] [RL12]
      dec_kind = rrs_pkg::rrs_shl_arith;
    else
      dec_ok = 1'b0;
  end

  // ==========================================
  // Byte-lane merge of a register write
  always_comb
  begin
    wmerge = reg_word(st, st.aw_addr, cnt_active);
    for (int i = 0; i < 4; i++)
    begin
      if (st.w_strb[i])
        wmerge[8*i +: 8] = st.w_data[8*i +: 8];
    end
  end

  // ==========================================
  // Next state
  always_comb
  begin
    next_st = st;
    start_go = 1'b0;
    next_st.mem_rd_en = 1'b0;
    next_st.mem_wr_en = 1'b0;

    // Write address and data capture, either order
    if (awvalid && st.awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && st.wready)
    begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;

    // Register write once both halves held
    if (st.aw_full && st.w_full && !st.bvalid)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = rrs_pkg::RESP_OKAY;
      unique case (st.aw_addr)
        rrs_pkg::OFF_CTRL:
        begin
          if (st.w_strb[0] && st.w_data[rrs_pkg::CTRL_START_BIT] && !cnt_active)
          begin
            if (dec_ok)
            begin
              start_go = 1'b1;
              next_st.done = 1'b0;
              next_st.form = dec_form;
              next_st.kind = dec_kind;
              next_st.rsel = op[2:0]; // [RL9]
              next_st.opnd = st.gpr[op[2:0]]; // [RL9]
              if (dec_form == rrs_pkg::rrs_form_idx)
                next_st.addr = 16'(dec_index + {{8{b2[7]}}, b2}); // [RL14]
              else
                next_st.addr = {st.gpr[rrs_pkg::REG_CODE_H],
                                st.gpr[rrs_pkg::REG_CODE_L]}; // [RL13]
            end
            else
              next_st.ill = 1'b1;
          end
        end
        rrs_pkg::OFF_STATUS:
        begin
          // Write one to clear
          if (st.w_strb[0] && st.w_data[rrs_pkg::STAT_DONE_BIT])
            next_st.done = 1'b0;
          if (st.w_strb[0] && st.w_data[rrs_pkg::STAT_ILL_BIT])
            next_st.ill = 1'b0;
        end
        rrs_pkg::OFF_INSN:
        begin
          if (!cnt_active)
            next_st.insn = wmerge;
        end
        rrs_pkg::OFF_GPR_LO:
        begin
          if (!cnt_active)
            next_st.gpr[3:0] = wmerge;
        end
        rrs_pkg::OFF_GPR_HI:
        begin
          if (!cnt_active)
          begin
            next_st.gpr[4] = wmerge[7:0];
            next_st.gpr[5] = wmerge[15:8];
            next_st.gpr[7] = wmerge[31:24];
          end
        end
        rrs_pkg::OFF_FLAGS:
        begin
          if (!cnt_active)
            next_st.flags = wmerge[7:0];
        end
        rrs_pkg::OFF_INDEX:
        begin
          if (!cnt_active)
          begin
            next_st.index_reg_first = wmerge[15:0];
            next_st.index_reg_second = wmerge[31:16];
          end
        end
        default: next_st.bresp = rrs_pkg::RESP_SLVERR;
      endcase
    end

    // Memory read, modify and write-back
    if (cnt_active && st.form != rrs_pkg::rrs_form_reg)
    begin
      if (cnt_t == rd_t)
      begin
        next_st.mem_rd_en = 1'b1; // [RL13] [RL14]
        next_st.mem_addr = st.addr;
      end
      // Synchronous memory: byte stands one cycle after the strobe
      if (cnt_t == 5'(rd_t + 5'h02))
        next_st.opnd = mem_rdata; // [RL13]
      if (cnt_t == wr_t)
      begin
        next_st.mem_wr_en = 1'b1; // [RL13]
        next_st.mem_addr = st.addr;
        next_st.mem_wdata = alu_res;
      end
    end

    // Commit at the last clock state; set wins over a clear
    if (cnt_at_end)
    begin
      next_st.flags = alu_flags; // [RL5] [RL6] [RL7]
      if (st.form == rrs_pkg::rrs_form_reg)
        next_st.gpr[st.rsel] = alu_res; // [RL9]
      next_st.done = 1'b1; // [RL8]
    end

    // Register reads
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_word(st, araddr, cnt_active);
      next_st.rresp = rrs_pkg::RESP_OKAY;
      if (araddr > rrs_pkg::OFF_INDEX || araddr[1:0] != 2'h0)
        next_st.rresp = rrs_pkg::RESP_SLVERR;
    end

    // Ready flags registered from the next occupancy
    next_st.awready = !next_st.aw_full;
    next_st.wready = !next_st.w_full;
    next_st.arready = !next_st.rvalid;

    // Synchronous reset
    if (!aresetn)
    begin
      next_st = '0;
      next_st.insn = rrs_pkg::INSN_RST;
      next_st.gpr = {8{rrs_pkg::GPR_RST}};
      next_st.flags = rrs_pkg::FLAGS_RST;
      next_st.index_reg_first = rrs_pkg::IDX_RST;
      next_st.index_reg_second = rrs_pkg::IDX_RST;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // ==========================================
  // Outputs straight from state
  assign awready = st.awready;
  assign wready = st.wready;
  assign bresp = st.bresp;
  assign bvalid = st.bvalid;
  assign arready = st.arready;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign rvalid = st.rvalid;
  assign mem_addr = st.mem_addr;
  assign mem_wdata = st.mem_wdata;
  assign mem_rd_en = st.mem_rd_en;
  assign mem_wr_en = st.mem_wr_en;

endmodule // rrs_unit
`default_nettype wire

// [inc/rrs_pkg.sv]
`default_nettype none
// ==========================================
// Shared constants and types
package rrs_pkg;

  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INSN = 8'h08;
  localparam logic [7:0] OFF_GPR_LO = 8'h0C;
  localparam logic [7:0] OFF_GPR_HI = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_INDEX = 8'h18;

  // ==========================================
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ILL_BIT = 2;
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_P = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;

  // ==========================================
  // Reset values
  localparam logic [31:0] INSN_RST = 32'h0000_0000;
  localparam logic [7:0] GPR_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] IDX_RST = 16'h0000;

  // ==========================================
  // Opcode bytes
  localparam logic [7:0] PFX_BITOP = 8'hCB;
  localparam logic [7:0] PFX_IDX_FIRST = 8'hDD;
  localparam logic [7:0] PFX_IDX_SECOND = 8'hFD;
  localparam logic [7:0] OPM_ROT_C = 8'h0E;
  localparam logic [7:0] OPM_ROT_T = 8'h1E;
  localparam logic [7:0] OPM_SHL = 8'h26;
  localparam logic [7:0] OPR_ROT_C_BASE = 8'h08;
  localparam logic [7:0] OPR_ROT_T_BASE = 8'h18;
  localparam logic [7:0] OPR_SHL_BASE = 8'h20;
  localparam logic [2:0] REG_CODE_MEM = 3'h6;
  localparam logic [2:0] REG_CODE_H = 3'h4;
  localparam logic [2:0] REG_CODE_L = 3'h5;

  // ==========================================
  // Clock states per form, one state per aclk
  localparam logic [4:0] TS_REG = 5'h08;
  localparam logic [4:0] TS_PTR = 5'h0F;
  localparam logic [4:0] TS_IDX = 5'h17;
  // Memory read and write states within an instruction
  localparam logic [4:0] PTR_RD_T = 5'h08;
  localparam logic [4:0] PTR_WR_T = 5'h0C;
  localparam logic [4:0] IDX_RD_T = 5'h10;
  localparam logic [4:0] IDX_WR_T = 5'h14;

  // ==========================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // Types
  typedef enum logic [1:0] {rrs_form_reg, rrs_form_ptr, rrs_form_idx} rrs_form_t;
  typedef enum logic [1:0] {rrs_rot_circ, rrs_rot_carry, rrs_shl_arith} rrs_kind_t;

endpackage
`default_nettype wire

// [logic/rrs_shift_alu.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Rotate and shift datapath with flag update
module rrs_shift_alu
(
  // Operation
  input wire rrs_pkg::rrs_kind_t kind,
  input wire logic [7:0] opnd,
  input wire logic [7:0] flags_in,
  // Outcome
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic carry;

  // Result and carry per operation
  always_comb
  begin
    result = opnd;
    carry = flags_in[rrs_pkg::FLG_C];
    unique case (kind)
      rrs_pkg::rrs_rot_circ:
      begin
        result = {opnd[0], opnd[7:1]}; // [RL1]
        carry = opnd[0]; // [RL1]
      end
      rrs_pkg::rrs_rot_carry:
      begin
        result = {flags_in[rrs_pkg::FLG_C], opnd[7:1]}; // [RL2]
        carry = opnd[0]; // [RL2]
      end
      rrs_pkg::rrs_shl_arith:
      begin
        result = {opnd[6:0], 1'b0}; // [RL3] [RL4]
        carry = opnd[7]; // [RL3]
      end
      default:
      begin
        result = opnd;
        carry = flags_in[rrs_pkg::FLG_C];
      end
    endcase
  end

  // Condition flags, bits 5 and 3 kept
  always_comb
  begin
    flags_out = flags_in;
    flags_out[rrs_pkg::FLG_S] = result[7]; // [RL5]
    flags_out[rrs_pkg::FLG_Z] = (result == 8'h00); // [RL6]
    flags_out[rrs_pkg::FLG_H] = 1'b0; // [RL7]
    flags_out[rrs_pkg::FLG_P] = ~^result; // [RL7]
    flags_out[rrs_pkg::FLG_N] = 1'b0; // [RL7]
    flags_out[rrs_pkg::FLG_C] = carry;
  end

endmodule // rrs_shift_alu
`default_nettype wire

// [logic/rrs_step_count.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Clock-state counter for one instruction
module rrs_step_count
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic [4:0] last,
  // State
  output logic [4:0] t_now,
  output logic active,
  output logic at_end
);

  typedef struct packed {
    logic active;
    logic [4:0] t;
  } rrs_cnt_t;

  rrs_cnt_t st;
  rrs_cnt_t next_st;

  // Count from zero up to last, then stop
  always_comb
  begin
    next_st = st;
    if (st.active)
    begin
      if (st.t == last)
        next_st.active = 1'b0;
      else
        next_st.t = 5'(st.t + 5'h01);
    end
    if (start)
    begin
      next_st.active = 1'b1;
      next_st.t = 5'h00;
    end
    if (!aresetn)
      next_st = '0;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  assign t_now = st.t;
  assign active = st.active;
  assign at_end = st.active && (st.t == last);

endmodule // rrs_step_count
`default_nettype wire

// [bench/rrs_unit_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker for the shift unit
module rrs_unit_chk
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Operand memory
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_q;
  logic [7:0] cap;
  // Capture the byte that the memory returns after a read strobe
  always_ff @(posedge aclk)
  begin
    rd_q <= mem_rd_en;
    if (rd_q)
      cap <= mem_rdata;
  end
  // ==========
  // Steps of a transfer
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rmw;
    mem_rd_en ##4 mem_wr_en;
  endsequence
  a_rd_pulse: assert property (mem_rd_en |=> !mem_rd_en)
    else $error("read strobe longer than one cycle");
  a_wr_pulse: assert property (mem_wr_en |=> !mem_wr_en)
    else $error("write strobe longer than one cycle");
  a_rd_then_wr: assert property (mem_rd_en |-> s_rmw)
    else $error("write back not four cycles after read");
  a_wb_same_addr: assert property (s_rmw |-> mem_addr == $past(mem_addr, 4))
    else $error("write back address differs from read address");
  a_wb_shifted: assert property (mem_wr_en |->
    mem_wdata[6:0] == cap[7:1] || mem_wdata == {cap[6:0], 1'b0})
    else $error("written byte is not a one place shift of the read byte");
  a_b_answer: assert property (s_both_taken |-> ##[2:3] bvalid)
    else $error("write response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response not held");
endmodule // rrs_unit_chk
`default_nettype wire

// [bench/rrs_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Byte memory behind the operand port
module rrs_mem_model
(
  // Clock
  input wire logic aclk,
  // Operand port
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  // One-cycle read; otherwise the bus toggles, so stale data stands only on alternate cycles
  always @(posedge aclk)
  begin
    if (mem_rd_en)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr_en)
      mem[mem_addr] <= mem_wdata;
  end
endmodule // rrs_mem_model
`default_nettype wire

// [bench/tb_rrs_unit.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench top
module tb_rrs_unit;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_rd_en, mem_wr_en;
  logic [7:0] awaddr, araddr, mem_wdata, mem_rdata;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] mem_addr;
  int error_cnt, comparisons, cyc, s_cyc, rd_cyc, wr_cyc;
  localparam logic [7:0] VALS [7] = '{8'h31, 8'h80, 8'h01, 8'hDD, 8'h00, 8'h7E, 8'hA5};
  localparam logic [7:0] OPS_R [3] = '{rrs_pkg::OPR_ROT_C_BASE, rrs_pkg::OPR_ROT_T_BASE,
    rrs_pkg::OPR_SHL_BASE};
  localparam logic [7:0] OPS_M [3] = '{rrs_pkg::OPM_ROT_C, rrs_pkg::OPM_ROT_T, rrs_pkg::OPM_SHL};
  rrs_unit u_dut (.*);
  rrs_mem_model u_mem (.*);
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Cycle count, strobe times and hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (mem_rd_en)
      rd_cyc <= cyc;
    if (mem_wr_en)
      wr_cyc <= cyc;
    if (cyc > 10000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (!(bvalid && bready))
        bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    s_cyc = cyc;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (!(rvalid && rready))
        rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask
  task automatic run(input logic [31:0] insn);
    axi_wr(rrs_pkg::OFF_INSN, insn, rrs_pkg::RESP_OKAY);
    axi_wr(rrs_pkg::OFF_CTRL, 32'h0000_0001, rrs_pkg::RESP_OKAY);
  endtask
  // Expected flags and result of one operation
  function automatic logic [15:0] model(input int k, input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    r = (k == 2) ? {v[6:0], 1'b0} : {(k == 0) ? v[0] : f[0], v[7:1]};
    return {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, (k == 2) ? v[7] : v[0], r};
  endfunction
  // ==========
  // Scenarios
  task automatic t_reg_forms;
    logic [7:0] r [8];
    logic [7:0] fin;
    logic [15:0] e;
    int n;
    n = 0;
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 8; c++)
      begin
        if (c == 6)
          continue;
        for (int i = 0; i < 8; i++)
          r[i] = 8'h5A ^ 8'(i);
        r[c] = VALS[n % 7];
        fin = 8'h28 | 8'(n % 2);
        e = model(k, r[c], fin);
        axi_wr(rrs_pkg::OFF_GPR_LO, {r[3], r[2], r[1], r[0]}, rrs_pkg::RESP_OKAY);
        axi_wr(rrs_pkg::OFF_GPR_HI, {r[7], 8'h00, r[5], r[4]}, rrs_pkg::RESP_OKAY);
        axi_wr(rrs_pkg::OFF_FLAGS, {24'h0, fin}, rrs_pkg::RESP_OKAY);
        run({16'h0, OPS_R[k] + 8'(c), rrs_pkg::PFX_BITOP});
        repeat (6 + n % 2) @(posedge aclk);
        axi_rd(rrs_pkg::OFF_STATUS);
        check("busy and done", {30'h0, n[0], ~n[0]}, d);
        r[c] = e[7:0];
        axi_rd(rrs_pkg::OFF_GPR_LO);
        check("low registers", {r[3], r[2], r[1], r[0]}, d);
        axi_rd(rrs_pkg::OFF_GPR_HI);
        check("high registers", {r[7], 8'h00, r[5], r[4]}, d);
        axi_rd(rrs_pkg::OFF_FLAGS);
        check("flags", {24'h0, e[15:8]}, d);
        n++;
      end
    $display("register forms finished");
  endtask
  task automatic t_mem_forms;
    logic [15:0] e, a;
    logic [7:0] v;
    int tr;
    axi_wr(rrs_pkg::OFF_GPR_HI, 32'h0000_4343, rrs_pkg::RESP_OKAY);
    axi_wr(rrs_pkg::OFF_INDEX, 32'h1000_1008, rrs_pkg::RESP_OKAY);
    for (int f = 0; f < 3; f++)
      for (int k = 0; k < 3; k++)
      begin
        a = (f == 0) ? 16'h4343 : (f == 1) ? 16'h0FF8 : 16'h1022;
        v = VALS[(f * 3 + k) % 7];
        u_mem.mem[a] = v;
        tr = (f == 0) ? 9 : 17;
        e = model(k, v, {7'h0, k[0]});
        axi_wr(rrs_pkg::OFF_FLAGS, {31'h0, k[0]}, rrs_pkg::RESP_OKAY);
        if (f == 0)
          run({16'h0, OPS_M[k], rrs_pkg::PFX_BITOP});
        else
          run({OPS_M[k], (f == 1) ? 8'hF0 : 8'h22, rrs_pkg::PFX_BITOP,
            (f == 1) ? rrs_pkg::PFX_IDX_FIRST : rrs_pkg::PFX_IDX_SECOND});
        repeat (26) @(posedge aclk);
        check("read strobe time", 32'(tr), 32'(rd_cyc - s_cyc));
        check("write strobe time", 32'(tr + 4), 32'(wr_cyc - s_cyc));
        check("memory byte", {24'h0, e[7:0]}, {24'h0, u_mem.mem[a]});
        axi_rd(rrs_pkg::OFF_FLAGS);
        check("flags", {24'h0, e[15:8]}, d);
      end
    $display("memory forms finished");
  endtask
  task automatic t_bus_edges;
    axi_rd(8'h1C);
    check("unmapped rresp", {30'h0, rrs_pkg::RESP_SLVERR}, {30'h0, rs});
    check("unmapped rdata", 32'h0, d);
    axi_wr(8'h40, 32'hFFFF_FFFF, rrs_pkg::RESP_SLVERR);
    run(32'h0001_CBDD);
    repeat (4) @(posedge aclk);
    axi_rd(rrs_pkg::OFF_STATUS);
    check("undecodable flag", 32'h4, d & 32'h5);
    axi_wr(rrs_pkg::OFF_STATUS, 32'h4, rrs_pkg::RESP_OKAY);
    axi_rd(rrs_pkg::OFF_STATUS);
    check("flag cleared", 32'h0, d & 32'h4);
    $display("bus edges finished");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {error_cnt, comparisons, cyc, rd_cyc, wr_cyc} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(rrs_pkg::OFF_FLAGS);
    check("flags after reset", 32'h0, d);
    t_reg_forms;
    t_mem_forms;
    t_bus_edges;
    print_verdict;
  end
endmodule // tb_rrs_unit
bind rrs_unit rrs_unit_chk u_chk (.*);
`default_nettype wire
